// File: design/tlia_arbiter.sv
// Purpose: Two-level interrupt enable, priority and vector arbitration
// Assumes: Core pulses INSTR_DONE at each instruction end, RETURN_FROM_INTERRUPT_DONE at return end
// Notes:   Flags come in as set pulses or levels; PEND register clears them
// Operation
// - High preempts low; high never preempted
// - All sources low priority after reset
// - High level first, then smallest order
// - Sample and decode every clock cycle
// - Best response one detect plus four-cycle call
// - After return, one instruction before call
// - Worst response eighteen cycles total
// - Equal or higher running level blocks request
// - Vector is 0x0003 plus eight times order
// - Hardware clears only pins and timers 0,1
// - Global enable bit 7 overrides masks
// - Primary enable bit layout, reset zero
// - Any enabled sub-flag raises source request
// - Extended enable and priority bit positions
// - Timer and pin requests from own flags
// - Flags set regardless of enable state
// - Flag still set after return re-requests
`timescale 1ns/1ps
module tlia_arbiter
  import tlia_pkg::*;
#(
  parameter int unsigned SUBFLAGS = 4
)(
  input  wire logic                          CLK_SYS,
  input  wire logic                          RESET_N,
  input  wire logic                          CLK_EN,
  input  wire logic [NUM_SLOTS*SUBFLAGS-1:0] SRC_FLAG_SET,
  input  wire logic [NUM_SLOTS*SUBFLAGS-1:0] SRC_SUB_MASK,
  input  wire logic                          INSTR_DONE,
  input  wire logic                          RETURN_FROM_INTERRUPT_DONE,
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [ADDR_W-1:0]             PADDR,
  input  wire logic [31:0]                   PWDATA,
  output logic      [31:0]                   PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  output logic                               CALL_REQ,
  output logic      [15:0]                   CALL_VECTOR,
  output logic                               CALL_ACTIVE,
  output logic                               HI_ACTIVE,
  output logic                               LO_ACTIVE
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]                    ie_pri_ff;
  logic [7:0]                    ip_pri_ff;
  logic [7:0]                    ie_ext_ff;
  logic [7:0]                    ip_ext_ff;
  logic [NUM_SLOTS*SUBFLAGS-1:0] pend_ff;
  logic [NUM_SLOTS-1:0]          src_en;
  logic [NUM_SLOTS-1:0]          src_hi;
  logic [NUM_SLOTS-1:0]          src_req;
  logic                          wr_acc;
  logic                          rd_acc;
  logic                          addr_ok;
  logic [31:0]                   nxt_prdata;

  assign wr_acc = PSEL && PENABLE && PWRITE && PREADY && CLK_EN;
  assign rd_acc = PSEL && PENABLE && !PWRITE && !PREADY && CLK_EN;
  assign addr_ok = (PADDR == ADDR_IE_PRI) || (PADDR == ADDR_IP_PRI) || (PADDR == ADDR_IE_EXT)
                || (PADDR == ADDR_IP_EXT) || (PADDR == ADDR_PEND) || (PADDR == ADDR_STATUS);

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      ie_pri_ff <= RST_ENABLE;
      ip_pri_ff <= RST_PRIO;
      ie_ext_ff <= RST_ENABLE;
      ip_ext_ff <= RST_PRIO;
    end
    else if (wr_acc)
    begin
      if (PADDR == ADDR_IE_PRI)
        ie_pri_ff <= PWDATA[7:0];
      if (PADDR == ADDR_IP_PRI)
        ip_pri_ff <= PWDATA[7:0] & ~IP_PRI_UNUSED;
      if (PADDR == ADDR_IE_EXT)
        ie_ext_ff <= PWDATA[7:0] & ~EXT_RSVD_MASK;
      if (PADDR == ADDR_IP_EXT)
        ip_ext_ff <= PWDATA[7:0] & ~EXT_RSVD_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration state
  // ----------------------------------------------------------------
  tlia_state_t         state_ff;
  logic [2:0]          cnt_ff;
  logic                hi_run_ff;
  logic                lo_run_ff;
  logic                hold_ff;
  logic                win_valid_ff;
  logic [SLOT_W-1:0]   win_slot_ff;
  logic                win_hi_ff;
  logic                win_valid;
  logic [SLOT_W-1:0]   win_slot;
  logic                win_hi;
  logic                take;

  // Enable/priority maps: slot 0..6 primary, 7 extended bit 0, 9..14 extended bits 2..7
  always_comb
  begin
    src_en = '0;
    src_hi = '0;
    for (int i = 0; i < 7; i++)
    begin
      src_en[i] = ie_pri_ff[i];
      src_hi[i] = ip_pri_ff[i];
    end
    src_en[7] = ie_ext_ff[0];
    src_hi[7] = ip_ext_ff[0];
    for (int i = 9; i < NUM_SLOTS; i++)
    begin
      src_en[i] = ie_ext_ff[i - 7];
      src_hi[i] = ip_ext_ff[i - 7];
    end
  end

  // Per-source request from any enabled sub-flag
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++)
    begin : g_req
      if (g == int'(SLOT_RESERVED))
      begin : g_rsv
        assign src_req[g] = 1'b0;
      end
      else
      begin : g_src
        assign src_req[g] = ie_pri_ff[GLOBAL_BIT] && src_en[g]
                          && |(pend_ff[g*SUBFLAGS +: SUBFLAGS] & SRC_SUB_MASK[g*SUBFLAGS +: SUBFLAGS]);
      end
    end
  endgenerate

  // Fixed order decode, high level first
  always_comb
  begin
    win_valid = 1'b0;
    win_slot  = '0;
    win_hi    = 1'b0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--)
      if (src_req[i] && !src_hi[i] && !hi_run_ff && !lo_run_ff)
      begin
        win_valid = 1'b1;
        win_slot  = SLOT_W'(i);
        win_hi    = 1'b0;
      end
    for (int i = NUM_SLOTS - 1; i >= 0; i--)
      if (src_req[i] && src_hi[i] && !hi_run_ff)
      begin
        win_valid = 1'b1;
        win_slot  = SLOT_W'(i);
        win_hi    = 1'b1;
      end
  end

  // Decode registered each cycle as the detect stage
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      win_valid_ff <= 1'b0;
      win_slot_ff  <= '0;
      win_hi_ff    <= 1'b0;
    end
    else if (CLK_EN)
    begin
      win_valid_ff <= win_valid;
      win_slot_ff  <= win_slot;
      win_hi_ff    <= win_hi;
    end
  end

  assign take = (state_ff == TL_IDLE) && win_valid_ff && win_valid && !hold_ff
             && (win_slot == win_slot_ff) && INSTR_DONE;

  // Post-return hold for one instruction
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
      hold_ff <= 1'b0;
    else if (CLK_EN)
    begin
      if (RETURN_FROM_INTERRUPT_DONE)
        hold_ff <= 1'b1;
      else if (INSTR_DONE)
        hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      state_ff <= TL_IDLE;
      cnt_ff   <= '0;
    end
    else if (CLK_EN)
    begin
      unique case (state_ff)
        TL_IDLE:
          if (take)
          begin
            state_ff <= TL_CALL;
            cnt_ff   <= '0;
          end
        TL_CALL:
          if (cnt_ff == CALL_LAST)
            state_ff <= TL_IDLE;
          else
            cnt_ff <= cnt_ff + 3'h1;
        TL_HOLD:
          state_ff <= TL_IDLE;
        default:
          state_ff <= TL_IDLE;
      endcase
    end
  end

  // Running service levels, cleared by the return
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      hi_run_ff <= 1'b0;
      lo_run_ff <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (take && win_hi)
        hi_run_ff <= 1'b1;
      else if (RETURN_FROM_INTERRUPT_DONE && hi_run_ff)
        hi_run_ff <= 1'b0;
      if (take && !win_hi)
        lo_run_ff <= 1'b1;
      else if (RETURN_FROM_INTERRUPT_DONE && lo_run_ff && !hi_run_ff)
        lo_run_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pending flags: set wins over clear
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < NUM_SLOTS; g++)
    begin : g_pend
      localparam logic HW_CLR = (g == int'(SLOT_EXT0)) || (g == int'(SLOT_TMR0))
                             || (g == int'(SLOT_EXT1)) || (g == int'(SLOT_TMR1));
      logic [SUBFLAGS-1:0] nxt_pend;
      always_comb
      begin
        nxt_pend = pend_ff[g*SUBFLAGS +: SUBFLAGS];
        if (HW_CLR && take && (win_slot == SLOT_W'(g)))
          nxt_pend = '0;
        if (wr_acc && (PADDR == ADDR_PEND) && PWDATA[g])
          nxt_pend = '0;
        nxt_pend = nxt_pend | SRC_FLAG_SET[g*SUBFLAGS +: SUBFLAGS];
      end
      always_ff @(posedge CLK_SYS)
      begin
        if (!RESET_N)
          pend_ff[g*SUBFLAGS +: SUBFLAGS] <= '0;
        else if (CLK_EN)
          pend_ff[g*SUBFLAGS +: SUBFLAGS] <= nxt_pend;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      CALL_REQ    <= 1'b0;
      CALL_VECTOR <= VEC_RESET;
      CALL_ACTIVE <= 1'b0;
      HI_ACTIVE   <= 1'b0;
      LO_ACTIVE   <= 1'b0;
    end
    else if (CLK_EN)
    begin
      CALL_REQ    <= take;
      if (take)
        CALL_VECTOR <= VEC_BASE + VEC_STEP * {12'h000, win_slot};
      CALL_ACTIVE <= take || ((state_ff == TL_CALL) && (cnt_ff != CALL_LAST));
      HI_ACTIVE   <= hi_run_ff;
      LO_ACTIVE   <= lo_run_ff;
    end
  end

  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    unique case (PADDR)
      ADDR_IE_PRI: nxt_prdata = {24'h000000, ie_pri_ff};
      ADDR_IP_PRI: nxt_prdata = {24'h000000, ip_pri_ff | IP_PRI_UNUSED};
      ADDR_IE_EXT: nxt_prdata = {24'h000000, ie_ext_ff};
      ADDR_IP_EXT: nxt_prdata = {24'h000000, ip_ext_ff};
      ADDR_PEND:   nxt_prdata = {17'h00000, src_req};
      ADDR_STATUS: nxt_prdata = {24'h000000, hi_run_ff, lo_run_ff, win_valid_ff, 1'b0, win_slot_ff};
      default:     nxt_prdata = 32'h0000_0000;
    endcase
  end

  // One wait state: answer in the cycle after the access phase starts
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else if (CLK_EN)
    begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !addr_ok;
      if (rd_acc)
        PRDATA <= nxt_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_reserved_slot: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    CALL_REQ |-> CALL_VECTOR != VEC_BASE + VEC_STEP * {12'h000, SLOT_RESERVED})
    else $error("Reserved slot called");
  chk_global_gate: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    !ie_pri_ff[GLOBAL_BIT] |-> !win_valid)
    else $error("Request while globally disabled");
  chk_hi_nopreempt: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    hi_run_ff |-> !take)
    else $error("High routine preempted");
  chk_call_length: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (CLK_EN && take) ##1 CLK_EN[*4] |=> state_ff == TL_IDLE)
    else $error("Call length wrong");
  chk_hold_after_ret: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    hold_ff |-> !take)
    else $error("Call without post-return instruction");
  chk_vec_range: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    CALL_REQ |-> (CALL_VECTOR >= VEC_BASE) && (CALL_VECTOR <= VEC_BASE + VEC_STEP * 16'(NUM_SLOTS - 1)))
    else $error("Vector out of range");
  chk_reset_prio: assert property (@(posedge CLK_SYS)
    $rose(RESET_N) |-> (ip_pri_ff == RST_PRIO) && (ip_ext_ff == RST_PRIO))
    else $error("Priority not low after reset");
  chk_decode_track: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    CLK_EN |=> win_valid_ff == $past(win_valid))
    else $error("Decode not sampled");

endmodule // tlia_arbiter

// File: design/tlia_pkg.sv
// Purpose: Constants for the two-level interrupt arbiter
// Assumes: 32-bit APB register access, one word per register
// Notes:   Source order numbers double as vector slots
package tlia_pkg;
  localparam int unsigned NUM_SLOTS     = 15;
  localparam int unsigned SLOT_W        = 4;
  localparam logic [3:0]  SLOT_RESERVED = 4'h8;
  localparam logic [3:0]  SLOT_EXT0     = 4'h0;
  localparam logic [3:0]  SLOT_TMR0     = 4'h1;
  localparam logic [3:0]  SLOT_EXT1     = 4'h2;
  localparam logic [3:0]  SLOT_TMR1     = 4'h3;
  localparam logic [15:0] VEC_BASE      = 16'h0003;
  localparam logic [15:0] VEC_STEP      = 16'h0008;
  localparam logic [15:0] VEC_RESET     = 16'h0000;
  // Register indices; byte address is four times the index
  localparam int unsigned ADDR_W        = 10;
  localparam logic [7:0]  IDX_IE_PRI    = 8'hA8;
  localparam logic [7:0]  IDX_IP_PRI    = 8'hB8;
  localparam logic [7:0]  IDX_IE_EXT    = 8'hE6;
  localparam logic [7:0]  IDX_IP_EXT    = 8'hF6;
  localparam logic [7:0]  IDX_PEND      = 8'h04;
  localparam logic [7:0]  IDX_STATUS    = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_IE_PRI = {IDX_IE_PRI, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IP_PRI = {IDX_IP_PRI, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IE_EXT = {IDX_IE_EXT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IP_EXT = {IDX_IP_EXT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PEND   = {IDX_PEND, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [7:0]  RST_ENABLE    = 8'h00;
  localparam logic [7:0]  RST_PRIO      = 8'h00;
  localparam logic [7:0]  IP_PRI_UNUSED = 8'h80;
  localparam logic [7:0]  EXT_RSVD_MASK = 8'h02;
  localparam int unsigned GLOBAL_BIT    = 7;
  // Timing in cycles
  localparam int unsigned DETECT_CYC    = 1;
  localparam int unsigned CALL_CYC      = 4;
  localparam int unsigned RETURN_FROM_INTERRUPT_CYC      = 5;
  localparam int unsigned DIV_CYC       = 8;
  localparam int unsigned BEST_CYC      = DETECT_CYC + CALL_CYC;
  localparam int unsigned WORST_CYC     = DETECT_CYC + RETURN_FROM_INTERRUPT_CYC + DIV_CYC + CALL_CYC;
  localparam logic [2:0]  CALL_LAST     = 3'(CALL_CYC - 1);
  typedef enum logic [1:0] {
    TL_IDLE = 2'b00,
    TL_CALL = 2'b01,
    TL_HOLD = 2'b11
  } tlia_state_t;
endpackage

// File: sim/tlia_core_model.sv
// Purpose: Core model driving instruction and return strobes
// Assumes: Fast core ends an instruction every cycle
// Notes:   Slow core runs divides; no instruction ends during a call
`timescale 1ns/1ps
module tlia_core_model
  import tlia_pkg::*;
(
  input  wire logic CLK_SYS,
  input  wire logic RESET_N,
  input  wire logic slow,
  input  wire logic return_from_interrupt_go,
  input  wire logic call_busy,
  output logic      instr_done,
  output logic      return_from_interrupt_done
);
  logic [2:0] cnt_ff;
  always_ff @(posedge CLK_SYS)
  begin
    cnt_ff    <= (!RESET_N || return_from_interrupt_go || call_busy) ? 3'h0 : cnt_ff + 3'h1;
    return_from_interrupt_done <= RESET_N && return_from_interrupt_go;
  end
  // Divide right after a return
  assign instr_done = RESET_N && !call_busy && (!slow || cnt_ff == 3'(DIV_CYC - 1));
endmodule // tlia_core_model

// File: sim/two_level_interrupt_arbiter_test.sv
// Purpose: Self-checking bench for the two-level interrupt arbiter
// Assumes: Core model drives instruction and return strobes
// Notes:   Slot g enable is primary bit g or extended bit g-7
`timescale 1ns/1ps
module two_level_interrupt_arbiter_test
  import tlia_pkg::*;
;
  localparam int SUB = 4;
  localparam int FW  = NUM_SLOTS * SUB;
  logic          clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic          slow = 1'b0, return_from_interrupt_go = 1'b0, pready, pslverr, call_req, call_active;
  logic          hi_active, lo_active, instr_done, return_from_interrupt_done, e, got;
  logic [9:0]    paddr = 10'h000;
  logic [31:0]   pwdata = 32'h0, prdata, r;
  logic [15:0]   call_vector, v;
  logic [FW-1:0] flag_set = '0;
  logic [FW-1:0] sub_mask = '1;
  int            error_cnt, comparisons, act, n;
  always #2.5 clk_sys = ~clk_sys;
  tlia_arbiter #(.SUBFLAGS(SUB)) DUT (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .CLK_EN(1'b1), .SRC_FLAG_SET(flag_set), .SRC_SUB_MASK(sub_mask),
    .INSTR_DONE(instr_done), .RETURN_FROM_INTERRUPT_DONE(return_from_interrupt_done), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CALL_REQ(call_req), .CALL_VECTOR(call_vector), .CALL_ACTIVE(call_active), .HI_ACTIVE(hi_active),
    .LO_ACTIVE(lo_active));
  tlia_core_model core (.CLK_SYS(clk_sys), .RESET_N(reset_n), .slow(slow), .return_from_interrupt_go(return_from_interrupt_go),
    .call_busy(call_active), .instr_done(instr_done), .return_from_interrupt_done(return_from_interrupt_done));
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    comparisons++;
    if (g !== x)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, m, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1 && n++ < 20);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t no bus answer", $time);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x, input logic xe, input string m);
    apb(1'b0, a, 32'h0);
    chk(r, x, m);
    chk(e, xe, m);
  endtask
  function automatic logic [FW-1:0] fl(input int g, input int s);
    return {{(FW-1){1'b0}}, 1'b1} << (g * SUB + s);
  endfunction
  task automatic pulse(input logic [FW-1:0] f);
    @(posedge clk_sys);
    flag_set <= f;
    @(posedge clk_sys);
    flag_set <= '0;
  endtask
  // Wait for a call, then count its active cycles
  task automatic wc(input int lim);
    got = 1'b0;
    for (n = 0; n < lim && got !== 1'b1; n++)
    begin
      @(posedge clk_sys);
      got = call_req;
      v   = call_vector;
    end
    for (act = 0; got === 1'b1 && call_active === 1'b1 && act < 10; act++)
      @(posedge clk_sys);
  endtask
  task automatic return_from_interrupt();
    @(posedge clk_sys);
    return_from_interrupt_go <= 1'b1;
    @(posedge clk_sys);
    return_from_interrupt_go <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rd(ADDR_IE_PRI, 32'h0, 1'b0, "ie reset");
    rd(ADDR_IP_PRI, 32'h80, 1'b0, "ip reset");
    wr(ADDR_IE_EXT, 32'hFF);
    rd(ADDR_IE_EXT, 32'hFD, 1'b0, "eie bits");
    wr(10'h080, 32'hFF);
    rd(10'h080, 32'h0, 1'b1, "unmapped");
  endtask
  task automatic t_vec();
    wr(ADDR_IE_PRI, 32'h01);
    pulse(fl(0, 0));
    wc(20);
    chk(got, 1'b0, "global off");
    for (int g = 0; g < NUM_SLOTS; g++)
    begin
      wr(ADDR_IE_EXT, g > 6 ? 32'h1 << (g - 7) : 32'h0);
      wr(ADDR_IE_PRI, g < 7 ? 32'h80 | (32'h1 << g) : 32'h80);
      if (g > 0)
        pulse(fl(g, g > 3 ? g % SUB : 0));
      wc(30);
      chk(got, g != 8, "call");
      if (got === 1'b1)
      begin
        chk(v, VEC_BASE + VEC_STEP * g, "vector");
        chk(act, CALL_CYC, "call cycles");
        return_from_interrupt();
      end
      wc(15);
      chk(got, g > 3 && g != 8, "reentry");
      wr(ADDR_PEND, 32'h1 << g);
      if (got === 1'b1)
        return_from_interrupt();
    end
  endtask
  task automatic t_return_from_interrupt();
    slow <= 1'b1;
    wr(ADDR_IE_PRI, 32'h90);
    pulse(fl(4, 0));
    wc(40);
    chk(got, 1'b1, "slow call");
    return_from_interrupt();
    got = 1'b0;
    n   = 0;
    do
    begin
      @(posedge clk_sys);
      got = got | call_req;
    end
    while (instr_done !== 1'b1 && n++ < 20);
    chk(got, 1'b0, "early call");
    wc(WORST_CYC);
    chk(got, 1'b1, "late call");
    wr(ADDR_PEND, 32'h10);
    return_from_interrupt();
    slow <= 1'b0;
  endtask
  task automatic t_mask();
    sub_mask <= ~fl(4, 1);
    wr(ADDR_IE_PRI, 32'h90);
    pulse(fl(4, 1));
    wc(15);
    chk(got, 1'b0, "masked sub");
    rd(ADDR_PEND, 32'h0, 1'b0, "pend masked");
    sub_mask <= '1;
    wc(15);
    chk(got, 1'b1, "unmasked sub");
    wr(ADDR_PEND, 32'h10);
    return_from_interrupt();
  endtask
  task automatic t_prio();
    wr(ADDR_IE_PRI, 32'hA2);
    pulse(fl(1, 0) | fl(5, 0));
    wc(30);
    chk(v, 32'h000B, "low tie");
    wc(15);
    chk(got, 1'b0, "equal held");
    wr(ADDR_IP_PRI, 32'h20);
    wc(15);
    chk(v, 32'h002B, "preempt");
    chk({hi_active, lo_active}, 2'b11, "nested");
    wr(ADDR_IP_PRI, 32'h22);
    pulse(fl(1, 0));
    wc(15);
    chk(got, 1'b0, "high kept");
  endtask
  task automatic close_out();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Several times the expected run
  initial
  begin
    #100000;
    error_cnt++;
    close_out();
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_vec();
    t_return_from_interrupt();
    t_mask();
    t_prio();
    close_out();
  end
endmodule // two_level_interrupt_arbiter_test
